/* verilog/cfg_handshake_map.svh */
`ifndef CFG_HANDSHAKE_MAP_SVH
`define CFG_HANDSHAKE_MAP_SVH
// Scheme encodings on the two-bit scheme select input.
`define SCHEME_PASSIVE 2'h0
`define SCHEME_SERIAL 2'h1
`define SCHEME_PARALLEL 2'h2
// Cycles spent in the initialization phase before user mode.
`define INIT_CYCLES 8'h10
`define INIT_CNT_ZERO 8'h00
`define INIT_CNT_ONE 8'h01
`endif

/* verilog/cfg_handshake_pkg.sv */
`default_nettype none
package cfg_handshake_pkg;
    typedef enum logic [2:0] {
        ST_RESET = 3'h0,
        ST_WAIT_ENABLE = 3'h1,
        ST_LOAD = 3'h3,
        ST_WAIT_FLAG = 3'h2,
        ST_INIT = 3'h6,
        ST_USER = 3'h7,
        ST_ERROR = 3'h5
    } phase_e;

    // Open-drain pin as seen from the logic.
    typedef struct packed {
        logic level;
        logic drive_low;
    } od_pin_s;

    typedef struct packed {
        logic pipe;
        logic level;
    } sync_s;

    typedef struct packed {
        phase_e phase;
        logic [7:0] init_cnt;
        logic flag_release;
        logic chain_out_drive;
        logic chain_out_user;
        logic select_low;
        logic error_drive;
    } ctrl_s;
endpackage
`default_nettype wire

/* verilog/pin_sync.sv */
`default_nettype none
module pin_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);
    cfg_handshake_pkg::sync_s s_q;
    cfg_handshake_pkg::sync_s s_d;

    // The first stage feeds only the second stage.
    always_comb begin
        s_d.pipe = async_in;
        s_d.level = s_q.pipe;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.level;
endmodule
`default_nettype wire

/* verilog/od_pin.sv */
`default_nettype none
module od_pin (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin_in,
    input wire logic pull_low,
    output logic pin_oe,
    output logic pin_out,
    output cfg_handshake_pkg::od_pin_s pin_state
);
    logic drive_q;
    logic level_sync;

    pin_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(pin_in),
        .sync_out(level_sync)
    );

    // Reset comes up driving low so a flag never floats high early.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_q <= 1'b1;
        end else begin
            drive_q <= pull_low;
        end
    end

    assign pin_oe = drive_q;
    assign pin_out = 1'b0;
    assign pin_state.drive_low = drive_q;
    assign pin_state.level = level_sync;
endmodule
`default_nettype wire

/* verilog/config_done_chain_handshake.sv */
`default_nettype none
`include "cfg_handshake_map.svh"
// Operation
// - Hold completion flag low during load
// - Release flag after error-free load ends
// - Initialize only after flag reads high
// - Ignore external flag low once configured
// - Load only while chain enable low
// - Drive chain output low when complete
// - Option off frees chain output pin
// - Serial scheme asserts memory select
// - Parallel scheme uses select as enable
// - Scheme decides role of select pin
// - Reconfig low resets, rising edge restarts
// - Pull error pin low on error
module config_done_chain_handshake (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load_complete_flag_in,
    output logic load_complete_flag_out,
    output logic load_complete_flag_oe,
    input wire logic chain_enable_in_low,
    output logic chain_enable_out_low_out,
    output logic chain_enable_out_low_oe,
    input wire logic chain_out_option_on,
    input wire logic chain_out_user_oe,
    input wire logic chain_out_user_value,
    input wire logic reconfig_request_low,
    input wire logic load_error_low_in,
    output logic load_error_low_out,
    output logic load_error_low_oe,
    input wire logic [1:0] scheme_select,
    output logic shared_select_low,
    output logic active_serial_scheme,
    output logic active_parallel_scheme,
    input wire logic load_words_done,
    input wire logic load_error_detect,
    output logic loading,
    output logic user_mode,
    output logic io_tristate
);
    cfg_handshake_pkg::ctrl_s c_q;
    cfg_handshake_pkg::ctrl_s c_d;
    cfg_handshake_pkg::od_pin_s flag_pin;
    cfg_handshake_pkg::od_pin_s error_pin;
    logic chain_en_low_s;
    logic reconfig_low_s;
    logic [1:0] scheme_s0;
    logic [1:0] scheme_s;

    // The completion flag and the error pin are wired-and lines shared with
    // other devices and a pull-up. Each pin block registers its drive-low
    // enable from the next state, so a pin follows the phase on the same
    // edge, and reports the pin level through two flip-flops.
    od_pin u_flag (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in(load_complete_flag_in),
        .pull_low(!c_d.flag_release),
        .pin_oe(load_complete_flag_oe),
        .pin_out(load_complete_flag_out),
        .pin_state(flag_pin)
    );

    // Apart from reset, only a fault found here drives the error line; a low
    // level seen from outside during load, flag wait or init moves this device to the error phase without echoing it.
    od_pin u_error (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in(load_error_low_in),
        .pull_low(c_d.error_drive),
        .pin_oe(load_error_low_oe),
        .pin_out(load_error_low_out),
        .pin_state(error_pin)
    );

    // Every pin below is asynchronous to clk. The state machine answers a
    // pin change on the third edge, far below any board-level timing.
    pin_sync u_chain (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(chain_enable_in_low),
        .sync_out(chain_en_low_s)
    );

    pin_sync u_reconf (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(reconfig_request_low),
        .sync_out(reconfig_low_s)
    );

    pin_sync u_sch0 (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(scheme_select[0]),
        .sync_out(scheme_s0[0])
    );

    pin_sync u_sch1 (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(scheme_select[1]),
        .sync_out(scheme_s0[1])
    );

    // The scheme pins are strapped on the board, so one synchronizer per
    // bit is enough; they never change while a load runs.
    assign scheme_s = scheme_s0;

    // Phase sequence: reset, wait for the chain enable, load, wait for the
    // shared flag to rise, a fixed initialization count, then user mode.
    // An error during load, flag wait or initialization parks the machine until the
    // next reconfiguration request, which is the only way out of it.
    // Every phase starts from a copy of the registered state.
    always_comb begin
        c_d = c_q;
        case (c_q.phase)
            cfg_handshake_pkg::ST_RESET: begin
                c_d.flag_release = 1'b0;
                c_d.chain_out_drive = 1'b0;
                c_d.chain_out_user = 1'b0;
                c_d.select_low = 1'b0;
                c_d.error_drive = 1'b0;
                c_d.init_cnt = `INIT_CNT_ZERO;
                // Leave only once the request pin reads high again.
                if (reconfig_low_s) begin
                    c_d.phase = cfg_handshake_pkg::ST_WAIT_ENABLE;
                end
            end

            cfg_handshake_pkg::ST_WAIT_ENABLE: begin
                // A high chain enable keeps the device out of loading; an
                // upstream device lowers it only once its own load is done.
                if (!chain_en_low_s) begin
                    c_d.phase = cfg_handshake_pkg::ST_LOAD;
                    c_d.select_low = 1'b1;
                end
            end

            cfg_handshake_pkg::ST_LOAD: begin
                // Errors are checked before completion so that a fault on
                // the last word is never reported as a finished load.
                c_d.flag_release = 1'b0;
                if (load_error_detect || !error_pin.level) begin
                    c_d.error_drive = load_error_detect;
                    c_d.select_low = 1'b0;
                    c_d.phase = cfg_handshake_pkg::ST_ERROR;
                end else if (chain_en_low_s) begin
                    c_d.select_low = 1'b0;
                    c_d.phase = cfg_handshake_pkg::ST_WAIT_ENABLE;
                end else if (load_words_done) begin
                    c_d.flag_release = 1'b1;
                    c_d.select_low = 1'b0;
                    c_d.phase = cfg_handshake_pkg::ST_WAIT_FLAG;
                end
            end

            cfg_handshake_pkg::ST_WAIT_FLAG: begin
                // The flag is wired-and with other devices and its pull-up,
                // so the slowest device of the chain holds everyone here.
                if (load_error_detect || !error_pin.level) begin
                    c_d.error_drive = load_error_detect;
                    c_d.phase = cfg_handshake_pkg::ST_ERROR;
                end else if (flag_pin.level) begin
                    c_d.init_cnt = `INIT_CYCLES;
                    c_d.phase = cfg_handshake_pkg::ST_INIT;
                end
            end

            cfg_handshake_pkg::ST_INIT: begin
                // A fault seen by any device of the chain aborts init too.
                if (load_error_detect || !error_pin.level) begin
                    c_d.error_drive = load_error_detect;
                    c_d.phase = cfg_handshake_pkg::ST_ERROR;
                end else if (c_q.init_cnt == `INIT_CNT_ONE) begin
                    c_d.init_cnt = `INIT_CNT_ZERO;
                    c_d.chain_out_drive = chain_out_option_on;
                    c_d.chain_out_user = !chain_out_option_on;
                    c_d.phase = cfg_handshake_pkg::ST_USER;
                end else begin
                    c_d.init_cnt = c_q.init_cnt - `INIT_CNT_ONE;
                end
            end

            cfg_handshake_pkg::ST_USER: begin
                // Flag and error levels are not looked at here, so a board
                // that pulls either line low later cannot unload the device.
                c_d.flag_release = 1'b1;
                c_d.error_drive = 1'b0;
                c_d.select_low = 1'b0;
            end

            cfg_handshake_pkg::ST_ERROR: begin
                // Stays here until a reconfiguration request. A fault found
                // here keeps the error line driven so the host can see it.
                c_d.select_low = 1'b0;
            end

            default: begin
                // An unused code, for instance after an upset, restarts.
                c_d.phase = cfg_handshake_pkg::ST_RESET;
            end
        endcase
        // Reconfiguration request overrides every phase. Clear wins over
        // any transition chosen above, so a request that lands on the edge
        // of load completion still restarts from reset.
        if (!reconfig_low_s) begin
            c_d.phase = cfg_handshake_pkg::ST_RESET;
            c_d.flag_release = 1'b0;
            c_d.chain_out_drive = 1'b0;
            c_d.chain_out_user = 1'b0;
            c_d.select_low = 1'b0;
            c_d.error_drive = 1'b0;
            c_d.init_cnt = `INIT_CNT_ZERO;
        end
    end

    // Reset leaves the flag pulled low so that no neighbour sees a false
    // completion while this device is still powering up. The error line is
    // pulled low too while reset is held, since its pin block resets driving.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            c_q.phase <= cfg_handshake_pkg::ST_RESET;
            c_q.init_cnt <= `INIT_CNT_ZERO;
            c_q.flag_release <= 1'b0;
            c_q.chain_out_drive <= 1'b0;
            c_q.chain_out_user <= 1'b0;
            c_q.select_low <= 1'b0;
            c_q.error_drive <= 1'b0;
        end else begin
            c_q <= c_d;
        end
    end

    // The chain output is open-drain; user mode may take it over. Before
    // user mode it stays released, so the next device of the chain never
    // starts loading early.
    always_comb begin
        chain_enable_out_low_out = 1'b0;
        chain_enable_out_low_oe = c_q.chain_out_drive;
        if (c_q.chain_out_user) begin
            chain_enable_out_low_out = chain_out_user_value;
            chain_enable_out_low_oe = chain_out_user_oe;
        end
    end

    // One pin, two roles: a passive scheme never asserts it. The role is
    // taken from the strapped scheme, so no mode register is needed.
    always_comb begin
        active_serial_scheme = 1'b0;
        active_parallel_scheme = 1'b0;
        shared_select_low = 1'b1;
        case (scheme_s)
            `SCHEME_SERIAL: begin
                active_serial_scheme = 1'b1;
                shared_select_low = !c_q.select_low;
            end
            `SCHEME_PARALLEL: begin
                active_parallel_scheme = 1'b1;
                shared_select_low = !c_q.select_low;
            end
            default: begin
                // Passive schemes leave the memory deselected.
                shared_select_low = 1'b1;
            end
        endcase
    end

    // Status comes from the registered phase only, so these outputs carry
    // no glitches from the pin synchronizers.
    always_comb begin
        loading = 1'b0;
        user_mode = 1'b0;
        io_tristate = 1'b1;
        case (c_q.phase)
            cfg_handshake_pkg::ST_LOAD: begin
                loading = 1'b1;
            end
            cfg_handshake_pkg::ST_USER: begin
                user_mode = 1'b1;
                io_tristate = 1'b0;
            end
            cfg_handshake_pkg::ST_ERROR: begin
                // A failed load never hands the pins to the user.
                io_tristate = 1'b1;
            end
            default: begin
                // Reset, waiting and init keep the user pins tri-stated.
                io_tristate = 1'b1;
            end
        endcase
    end
endmodule
`default_nettype wire

/* tb/config_done_chain_handshake_properties.sv */
`default_nettype none
module config_done_chain_handshake_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load_complete_flag_in,
    input wire logic load_complete_flag_oe,
    input wire logic chain_enable_in_low,
    input wire logic chain_enable_out_low_oe,
    input wire logic chain_out_option_on,
    input wire logic reconfig_request_low,
    input wire logic shared_select_low,
    input wire logic active_serial_scheme,
    input wire logic active_parallel_scheme,
    input wire logic load_error_detect,
    input wire logic load_error_low_oe,
    input wire logic loading,
    input wire logic user_mode,
    input wire logic io_tristate
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_hold; loading |-> load_complete_flag_oe; endproperty
    a_hold: assert property (p_hold) else $error("flag freed");
    // Synchronizers delay pin levels, so windows span five samples.
    property p_init; $rose(user_mode) |-> $past(load_complete_flag_in, 4);
    endproperty
    a_init: assert property (p_init) else $error("early init");
    property p_keep; reconfig_request_low [*5] ##0 user_mode |=> user_mode;
    endproperty
    a_keep: assert property (p_keep) else $error("user lost");
    property p_noload; chain_enable_in_low [*5] |-> !$rose(loading);
    endproperty
    a_noload: assert property (p_noload) else $error("load");
    property p_chain; $rose(user_mode) && chain_out_option_on |=>
        chain_enable_out_low_oe; endproperty
    a_chain: assert property (p_chain) else $error("chain idle");
    property p_sel; loading && (active_serial_scheme || active_parallel_scheme)
        |-> !shared_select_low; endproperty
    a_sel: assert property (p_sel) else $error("no select");
    property p_clr; (!reconfig_request_low) [*5] |-> io_tristate && !user_mode;
    endproperty
    a_clr: assert property (p_clr) else $error("not cleared");
    property p_err; load_error_detect && loading |-> ##[1:2] load_error_low_oe;
    endproperty
    a_err: assert property (p_err) else $error("no error");
endmodule
`default_nettype wire

/* tb/cfg_partner.sv */
`default_nettype none
module cfg_partner (
    input wire logic load_complete_flag_out,
    input wire logic load_complete_flag_oe,
    input wire logic ext_flag_low,
    input wire logic load_error_low_out,
    input wire logic load_error_low_oe,
    input wire logic chain_enable_out_low_out,
    input wire logic chain_enable_out_low_oe,
    output logic load_complete_flag_in,
    output logic load_error_low_in,
    output logic chain_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // Each line has a pull-up, so a released line reads high.
    assign load_complete_flag_in = ~(load_complete_flag_oe
        & ~load_complete_flag_out) & ~ext_flag_low;
    assign load_error_low_in = ~(load_error_low_oe & ~load_error_low_out);
    // The next device in the chain would see this line.
    assign chain_line = chain_enable_out_low_oe ? chain_enable_out_low_out
        : 1'b1;
endmodule
`default_nettype wire

/* tb/config_done_chain_handshake_tb.sv */
`default_nettype none
module config_done_chain_handshake_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, chain_enable_in_low = 1'b1;
    logic chain_out_option_on = 1'b1, chain_out_user_oe = 1'b0;
    logic chain_out_user_value = 1'b0, reconfig_request_low = 1'b0;
    logic load_words_done = 1'b0, load_error_detect = 1'b0;
    logic ext_flag_low = 1'b0;
    logic [1:0] scheme_select = 2'h0;
    wire logic load_complete_flag_in, load_complete_flag_out;
    wire logic load_complete_flag_oe, chain_enable_out_low_out;
    wire logic chain_enable_out_low_oe, load_error_low_in, load_error_low_out;
    wire logic load_error_low_oe, shared_select_low, active_serial_scheme;
    wire logic active_parallel_scheme, loading, user_mode, io_tristate;
    wire logic chain_line;
    int errors = 0;
    int checks = 0;
    config_done_chain_handshake DUT (
        .clk(clk),
        .rst_n(rst_n),
        .load_complete_flag_in(load_complete_flag_in),
        .load_complete_flag_out(load_complete_flag_out),
        .load_complete_flag_oe(load_complete_flag_oe),
        .chain_enable_in_low(chain_enable_in_low),
        .chain_enable_out_low_out(chain_enable_out_low_out),
        .chain_enable_out_low_oe(chain_enable_out_low_oe),
        .chain_out_option_on(chain_out_option_on),
        .chain_out_user_oe(chain_out_user_oe),
        .chain_out_user_value(chain_out_user_value),
        .reconfig_request_low(reconfig_request_low),
        .load_error_low_in(load_error_low_in),
        .load_error_low_out(load_error_low_out),
        .load_error_low_oe(load_error_low_oe),
        .scheme_select(scheme_select),
        .shared_select_low(shared_select_low),
        .active_serial_scheme(active_serial_scheme),
        .active_parallel_scheme(active_parallel_scheme),
        .load_words_done(load_words_done),
        .load_error_detect(load_error_detect),
        .loading(loading),
        .user_mode(user_mode),
        .io_tristate(io_tristate)
    );
    cfg_partner far_side (
        .load_complete_flag_out(load_complete_flag_out),
        .load_complete_flag_oe(load_complete_flag_oe),
        .ext_flag_low(ext_flag_low),
        .load_error_low_out(load_error_low_out),
        .load_error_low_oe(load_error_low_oe),
        .chain_enable_out_low_out(chain_enable_out_low_out),
        .chain_enable_out_low_oe(chain_enable_out_low_oe),
        .load_complete_flag_in(load_complete_flag_in),
        .load_error_low_in(load_error_low_in),
        .chain_line(chain_line)
    );
    always #5 clk = ~clk;
    task automatic chk(string n, logic e, logic g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic restart(logic o);
        @(posedge clk) reconfig_request_low <= 1'b0;
        cyc(6);
        chk("io_tristate", 1'b1, io_tristate);
        chk("user_mode", 1'b0, user_mode);
        @(posedge clk) begin
            reconfig_request_low <= 1'b1;
            chain_out_option_on <= o;
        end
    endtask
    task automatic wait_load();
        repeat (40) if (loading !== 1'b1) cyc(1);
        cyc(1);
    endtask
    task automatic t_disabled();
        restart(1'b1);
        cyc(20);
        chk("loading", 1'b0, loading);
        chk("select", 1'b1, shared_select_low);
        @(posedge clk) chain_enable_in_low <= 1'b0;
        wait_load();
        chk("loading", 1'b1, loading);
        $display("disabled chain test done");
    endtask
    task automatic t_boot(logic [1:0] s, logic o);
        @(posedge clk) scheme_select <= s;
        restart(o);
        wait_load();
        chk("flag_oe", 1'b1, load_complete_flag_oe);
        chk("chain_oe", 1'b0, chain_enable_out_low_oe);
        chk("select", s == 2'h0, shared_select_low);
        chk("serial", s == 2'h1, active_serial_scheme);
        chk("parallel", s == 2'h2, active_parallel_scheme);
        // The far side holds the flag low to show that init waits for it.
        @(posedge clk) begin
            load_words_done <= 1'b1;
            ext_flag_low <= 1'b1;
        end
        @(posedge clk) load_words_done <= 1'b0;
        cyc(3);
        chk("flag_oe", 1'b0, load_complete_flag_oe);
        cyc(30);
        chk("user_mode", 1'b0, user_mode);
        @(posedge clk) ext_flag_low <= 1'b0;
        cyc(30);
        chk("user_mode", 1'b1, user_mode);
        chk("chain_line", !o, chain_line);
        @(posedge clk) ext_flag_low <= 1'b1;
        cyc(10);
        chk("user_mode", 1'b1, user_mode);
        @(posedge clk) ext_flag_low <= 1'b0;
        $display("boot test done");
    endtask
    task automatic t_user_io();
        @(posedge clk) chain_out_user_oe <= 1'b1;
        cyc(2);
        chk("chain_line", 1'b0, chain_line);
        @(posedge clk) chain_out_user_value <= 1'b1;
        cyc(2);
        chk("chain_line", 1'b1, chain_line);
        @(posedge clk) chain_out_user_oe <= 1'b0;
        $display("user io test done");
    endtask
    task automatic t_error();
        restart(1'b1);
        wait_load();
        @(posedge clk) load_error_detect <= 1'b1;
        @(posedge clk) load_error_detect <= 1'b0;
        cyc(3);
        chk("err_line", 1'b0, load_error_low_in);
        chk("loading", 1'b0, loading);
        cyc(30);
        chk("user_mode", 1'b0, user_mode);
        restart(1'b1);
        cyc(2);
        chk("err_line", 1'b1, load_error_low_in);
        $display("error test done");
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // The sequence needs under a thousand cycles; this allows five times.
    initial begin
        #50us;
        errors++;
        test_done();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_disabled();
        t_boot(2'h0, 1'b1);
        t_boot(2'h1, 1'b0);
        t_user_io();
        t_boot(2'h2, 1'b1);
        t_error();
        test_done();
    end
endmodule
bind config_done_chain_handshake config_done_chain_handshake_properties
    props (
    .clk(clk),
    .rst_n(rst_n),
    .load_complete_flag_in(load_complete_flag_in),
    .load_complete_flag_oe(load_complete_flag_oe),
    .chain_enable_in_low(chain_enable_in_low),
    .chain_enable_out_low_oe(chain_enable_out_low_oe),
    .chain_out_option_on(chain_out_option_on),
    .reconfig_request_low(reconfig_request_low),
    .shared_select_low(shared_select_low),
    .active_serial_scheme(active_serial_scheme),
    .active_parallel_scheme(active_parallel_scheme),
    .load_error_detect(load_error_detect),
    .load_error_low_oe(load_error_low_oe),
    .loading(loading),
    .user_mode(user_mode),
    .io_tristate(io_tristate)
);
`default_nettype wire
